// file: sehier_pkg.sv
// package: shared constants and types for the status event hierarchy
//
// What this block does
// - each status register has five independent 16-bit parts, same bit per source
// - bit 15 always reads zero in every part
// - live condition bits come from synchronised hardware inputs or lower sum bits
// - live condition is read-only; writes ignored; reads change nothing
// - rising edge of a condition bit sets its event bit only if rising filter set
// - falling edge of a condition bit sets its event bit only if falling filter set
// - both filters are host read/write; reading leaves them unchanged
// - event part latches filtered transitions until the host reads it
// - event part is read-only; reading it clears all bits except hits arriving in the read cycle
// - sum bit is OR of event bits ANDed with enable mask
// - enable mask is host read/write; reading leaves it unchanged
// - sum bit is continuous and drives a condition bit of the higher register
// - summary byte collects standard event, operation and questionable summaries
// - state kept in host-readable status registers; the error queue is outside, only its nonempty flag enters
// - bit 6 is master summary; mask bit 6 ignored; request on enabled rise
// - parallel-poll flag is OR of summary byte ANDed with poll mask, bit 6 included
// - summary bits 2, 4, 5 show error queue, waiting message, standard event
package sehier_pkg;

  // ----------------------------------------------------------------
  // register parts
  // ----------------------------------------------------------------
  localparam int SEHIER_W = 16;
  localparam logic [15:0] SEHIER_LIVE_MASK = 16'h7fff;
  localparam logic [15:0] SEHIER_RISE_RST = 16'h7fff;
  localparam logic [15:0] SEHIER_FALL_RST = 16'h0000;
  localparam logic [15:0] SEHIER_EVT_RST = 16'h0000;
  localparam logic [15:0] SEHIER_MASK_RST = 16'h0000;

  // part select of a status register access
  localparam logic [2:0] SEHIER_PART_LIVE = 3'h0;
  localparam logic [2:0] SEHIER_PART_RISE = 3'h1;
  localparam logic [2:0] SEHIER_PART_FALL = 3'h2;
  localparam logic [2:0] SEHIER_PART_EVT = 3'h3;
  localparam logic [2:0] SEHIER_PART_MASK = 3'h4;

  // register select
  localparam logic [2:0] SEHIER_REG_OPER = 3'h0;
  localparam logic [2:0] SEHIER_REG_QUES = 3'h1;
  localparam logic [2:0] SEHIER_REG_DEV = 3'h2;
  localparam logic [2:0] SEHIER_REG_STDEV = 3'h3;
  localparam logic [2:0] SEHIER_REG_SUMMARY = 3'h4;
  localparam int SEHIER_NREG = 3;

  // summary byte bits
  localparam int SEHIER_SB_DEV = 1;
  localparam int SEHIER_SB_ERRQ = 2;
  localparam int SEHIER_SB_QUES = 3;
  localparam int SEHIER_SB_MSG = 4;
  localparam int SEHIER_SB_STDEV = 5;
  localparam int SEHIER_SB_MSS = 6;
  localparam int SEHIER_SB_OPER = 7;

  // summary group part selects
  localparam logic [2:0] SEHIER_SP_BYTE = 3'h0;
  localparam logic [2:0] SEHIER_SP_SRQ_MASK = 3'h1;
  localparam logic [2:0] SEHIER_SP_POLL_MASK = 3'h2;
  localparam logic [2:0] SEHIER_SP_STD_FLAGS = 3'h3;
  localparam logic [2:0] SEHIER_SP_STD_MASK = 3'h4;

  // ----------------------------------------------------------------
  // host command and answer carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] reg_sel;
    logic [2:0] part;
    logic [15:0] wdata;
  } sehier_cmd_s;

  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } sehier_rsp_s;

endpackage

// file: sehier_scpi_reg.sv
// module: one five-part status register with transition filters and sum bit
`timescale 1ns/10ps
`default_nettype none
module sehier_scpi_reg
  import sehier_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] live_in,
  input wire logic wr_rise,
  input wire logic wr_fall,
  input wire logic wr_mask,
  input wire logic rd_evt,
  input wire logic [15:0] wdata,
  output logic [15:0] live_condition,
  output logic [15:0] rising_filter,
  output logic [15:0] falling_filter,
  output logic [15:0] latched_events,
  output logic [15:0] event_mask,
  output logic sum_bit
);

  logic [15:0] prev_live;
  logic [15:0] rise_hit;
  logic [15:0] fall_hit;

  // live part follows hardware, never written by the host
  assign live_condition = live_in & SEHIER_LIVE_MASK;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_live <= 16'h0000;
    end else begin
      prev_live <= live_condition;
    end
  end

  assign rise_hit = live_condition & ~prev_live & rising_filter;
  assign fall_hit = ~live_condition & prev_live & falling_filter;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rising_filter <= SEHIER_RISE_RST;
      falling_filter <= SEHIER_FALL_RST;
      event_mask <= SEHIER_MASK_RST;
    end else begin
      if (wr_rise) begin
        rising_filter <= wdata & SEHIER_LIVE_MASK;
      end
      if (wr_fall) begin
        falling_filter <= wdata & SEHIER_LIVE_MASK;
      end
      if (wr_mask) begin
        event_mask <= wdata & SEHIER_LIVE_MASK;
      end
    end
  end

  // new hits are ORed after the clear so a simultaneous event survives
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latched_events <= SEHIER_EVT_RST;
    end else if (rd_evt) begin
      latched_events <= (rise_hit | fall_hit) & SEHIER_LIVE_MASK;
    end else begin
      latched_events <= (latched_events | rise_hit | fall_hit) & SEHIER_LIVE_MASK;
    end
  end

  assign sum_bit = |(latched_events & event_mask);

endmodule
`default_nettype wire

// file: sehier_top.sv
// module: status event hierarchy top with summary byte, service request and poll flag
`timescale 1ns/10ps
`default_nettype none
module sehier_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire sehier_pkg::sehier_cmd_s host_cmd,
  output sehier_pkg::sehier_rsp_s host_rsp,
  input wire logic [15:0] oper_src,
  input wire logic [15:0] ques_src,
  input wire logic [15:0] dev_src,
  input wire logic [7:0] std_event_pulse,
  input wire logic error_queue_nonempty,
  input wire logic message_waiting,
  output logic service_request,
  output logic poll_flag
);
  import sehier_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers (three stages, change when stages 2 and 3 agree)
  // ----------------------------------------------------------------
  localparam int PINW = 16 * 3 + 8 + 2;
  logic [PINW-1:0] pin_raw;
  logic [PINW-1:0] sync_a;
  logic [PINW-1:0] sync_b;
  logic [PINW-1:0] sync_c;
  logic [PINW-1:0] pin_q;

  assign pin_raw = {oper_src, ques_src, dev_src, std_event_pulse,
                    error_queue_nonempty, message_waiting};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_q <= '0;
    end else begin
      for (int i = 0; i < PINW; i++) begin
        if (sync_b[i] == sync_c[i]) begin
          pin_q[i] <= sync_c[i];
        end
      end
    end
  end

  logic [15:0] oper_q;
  logic [15:0] ques_q;
  logic [15:0] dev_q;
  logic [7:0] std_q;
  logic errq_q;
  logic msg_q;
  assign {oper_q, ques_q, dev_q, std_q, errq_q, msg_q} = pin_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic hit(input sehier_cmd_s c, input logic wr, input logic [2:0] r,
                               input logic [2:0] p);
    hit = c.valid && (c.write == wr) && (c.reg_sel == r) && (c.part == p);
  endfunction

  // ----------------------------------------------------------------
  // status registers: operation, questionable, device
  // ----------------------------------------------------------------
  logic [15:0] reg_live [SEHIER_NREG];
  logic [15:0] reg_rise [SEHIER_NREG];
  logic [15:0] reg_fall [SEHIER_NREG];
  logic [15:0] reg_evt [SEHIER_NREG];
  logic [15:0] reg_mask [SEHIER_NREG];
  logic [SEHIER_NREG-1:0] reg_sum;
  logic [15:0] reg_src [SEHIER_NREG];

  // device summary enters the questionable register as a lower-level sum
  assign reg_src[0] = oper_q;
  assign reg_src[1] = {ques_q[15:1], reg_sum[2]};
  assign reg_src[2] = dev_q;

  for (genvar g = 0; g < SEHIER_NREG; g++) begin : g_reg
    sehier_scpi_reg u_reg (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .live_in(reg_src[g]),
      .wr_rise(hit(host_cmd, 1'b1, 3'(g), SEHIER_PART_RISE)),
      .wr_fall(hit(host_cmd, 1'b1, 3'(g), SEHIER_PART_FALL)),
      .wr_mask(hit(host_cmd, 1'b1, 3'(g), SEHIER_PART_MASK)),
      .rd_evt(hit(host_cmd, 1'b0, 3'(g), SEHIER_PART_EVT)),
      .wdata(host_cmd.wdata),
      .live_condition(reg_live[g]),
      .rising_filter(reg_rise[g]),
      .falling_filter(reg_fall[g]),
      .latched_events(reg_evt[g]),
      .event_mask(reg_mask[g]),
      .sum_bit(reg_sum[g])
    );
  end

  // ----------------------------------------------------------------
  // standard event flags and mask
  // ----------------------------------------------------------------
  logic [7:0] standard_event_flags;
  logic [7:0] standard_event_mask;
  logic std_rd;
  assign std_rd = hit(host_cmd, 1'b0, SEHIER_REG_SUMMARY, SEHIER_SP_STD_FLAGS);

  // flags are sticky; a pulse in the read cycle stays set
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      standard_event_flags <= 8'h00;
    end else if (std_rd) begin
      standard_event_flags <= std_q;
    end else begin
      standard_event_flags <= standard_event_flags | std_q;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      standard_event_mask <= 8'h00;
    end else if (hit(host_cmd, 1'b1, SEHIER_REG_SUMMARY, SEHIER_SP_STD_MASK)) begin
      standard_event_mask <= host_cmd.wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // summary byte, service request and parallel poll
  // ----------------------------------------------------------------
  logic [7:0] service_request_mask;
  logic [7:0] parallel_poll_mask;
  logic [7:0] sum_raw;
  logic [7:0] top_summary_byte;
  logic master_summary_bit;
  logic [7:0] prev_enabled;
  logic [7:0] enabled_now;

  always_comb begin
    sum_raw = 8'h00;
    sum_raw[SEHIER_SB_DEV] = reg_sum[2];
    sum_raw[SEHIER_SB_ERRQ] = errq_q;
    sum_raw[SEHIER_SB_QUES] = reg_sum[1];
    sum_raw[SEHIER_SB_MSG] = msg_q;
    sum_raw[SEHIER_SB_STDEV] = |(standard_event_flags & standard_event_mask);
    sum_raw[SEHIER_SB_OPER] = reg_sum[0];
  end

  // mask bit 6 ignored when forming the master summary
  assign enabled_now = sum_raw & service_request_mask & ~(8'h01 << SEHIER_SB_MSS);
  assign master_summary_bit = |enabled_now;

  always_comb begin
    top_summary_byte = sum_raw;
    top_summary_byte[SEHIER_SB_MSS] = master_summary_bit;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      service_request_mask <= 8'h00;
      parallel_poll_mask <= 8'h00;
    end else begin
      if (hit(host_cmd, 1'b1, SEHIER_REG_SUMMARY, SEHIER_SP_SRQ_MASK)) begin
        service_request_mask <= host_cmd.wdata[7:0];
      end
      if (hit(host_cmd, 1'b1, SEHIER_REG_SUMMARY, SEHIER_SP_POLL_MASK)) begin
        parallel_poll_mask <= host_cmd.wdata[7:0];
      end
    end
  end

  // request pulses for one cycle whenever any enabled bit rises; bits rising together give one pulse
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_enabled <= 8'h00;
      service_request <= 1'b0;
    end else begin
      prev_enabled <= enabled_now;
      service_request <= |(enabled_now & ~prev_enabled);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      poll_flag <= 1'b0;
    end else begin
      poll_flag <= |(top_summary_byte & parallel_poll_mask);
    end
  end

  // ----------------------------------------------------------------
  // read answer, one cycle after the command
  // ----------------------------------------------------------------
  function automatic logic [15:0] part_of(input logic [2:0] p, input logic [15:0] lv,
                                          input logic [15:0] ri, input logic [15:0] fa,
                                          input logic [15:0] ev, input logic [15:0] mk);
    case (p)
      SEHIER_PART_LIVE: part_of = lv;
      SEHIER_PART_RISE: part_of = ri;
      SEHIER_PART_FALL: part_of = fa;
      SEHIER_PART_EVT: part_of = ev;
      SEHIER_PART_MASK: part_of = mk;
      default: part_of = 16'h0000;
    endcase
  endfunction

  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    case (host_cmd.reg_sel)
      SEHIER_REG_OPER, SEHIER_REG_QUES, SEHIER_REG_DEV: begin
        next_rdata = part_of(host_cmd.part, reg_live[host_cmd.reg_sel[1:0]],
                             reg_rise[host_cmd.reg_sel[1:0]],
                             reg_fall[host_cmd.reg_sel[1:0]],
                             reg_evt[host_cmd.reg_sel[1:0]],
                             reg_mask[host_cmd.reg_sel[1:0]]);
      end
      SEHIER_REG_SUMMARY: begin
        case (host_cmd.part)
          SEHIER_SP_BYTE: next_rdata = {8'h00, top_summary_byte};
          SEHIER_SP_SRQ_MASK: next_rdata = {8'h00, service_request_mask & 8'hbf};
          SEHIER_SP_POLL_MASK: next_rdata = {8'h00, parallel_poll_mask};
          SEHIER_SP_STD_FLAGS: next_rdata = {8'h00, standard_event_flags};
          SEHIER_SP_STD_MASK: next_rdata = {8'h00, standard_event_mask};
          default: next_rdata = 16'h0000;
        endcase
      end
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      host_rsp <= '0;
    end else begin
      host_rsp.valid <= host_cmd.valid && !host_cmd.write;
      host_rsp.rdata <= (host_cmd.valid && !host_cmd.write) ? (next_rdata & 16'h7fff) : 16'h0000;
    end
  end

endmodule
`default_nettype wire

// file: sehier_checker_assertions.sv
// checker: port-level properties of the status event hierarchy
`timescale 1ns/10ps
`default_nettype none
module sehier_checker
  import sehier_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire sehier_pkg::sehier_cmd_s host_cmd,
  input wire sehier_pkg::sehier_rsp_s host_rsp,
  input wire logic [15:0] oper_src,
  input wire logic error_queue_nonempty,
  input wire logic service_request,
  input wire logic poll_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic rd, wr, sg, ev_rd, rw_part;
  assign rd = host_cmd.valid && !host_cmd.write;
  assign wr = host_cmd.valid && host_cmd.write;
  assign sg = host_cmd.reg_sel == SEHIER_REG_SUMMARY;
  assign ev_rd = rd && host_cmd.reg_sel == SEHIER_REG_OPER && host_cmd.part == SEHIER_PART_EVT;
  // in the three status registers only filters and mask hold what is written
  assign rw_part = host_cmd.reg_sel < SEHIER_REG_STDEV && host_cmd.part != SEHIER_PART_LIVE
    && host_cmd.part != SEHIER_PART_EVT && host_cmd.part <= SEHIER_PART_MASK;
  // ----
  // host answers
  // ----
  property p_answer; rd |=> host_rsp.valid; endproperty
  a_answer: assert property (p_answer) else $error("read got no answer");
  property p_top_bit; host_rsp.rdata[15] == 1'b0; endproperty
  a_top_bit: assert property (p_top_bit) else $error("bit 15 read as one");
  // six quiet cycles cover the input synchroniser
  property p_live;
    $stable(oper_src)[*6] ##0 (rd && host_cmd.reg_sel == SEHIER_REG_OPER
      && host_cmd.part == SEHIER_PART_LIVE) |=> host_rsp.rdata == ($past(oper_src) & 16'h7fff);
  endproperty
  a_live: assert property (p_live) else $error("live part differs from inputs");
  property p_evt_clear;
    $stable(oper_src)[*8] ##0 ev_rd ##1 ev_rd |=> host_rsp.rdata == 16'h0000;
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("events survived a read");
  property p_readback;
    wr && rw_part ##1 rd && $stable(host_cmd.reg_sel) && $stable(host_cmd.part)
      |=> host_rsp.rdata == ($past(host_cmd.wdata, 2) & 16'h7fff);
  endproperty
  a_readback: assert property (p_readback) else $error("written part reads back wrong");
  // ----
  // request and poll outputs
  // ----
  property p_srq_quiet;
    wr && sg && host_cmd.part == SEHIER_SP_SRQ_MASK && (host_cmd.wdata[7:0] & 8'hbf) == 8'h00
      |-> ##3 !service_request [*5];
  endproperty
  a_srq_quiet: assert property (p_srq_quiet) else $error("request with empty mask");
  property p_poll_off;
    wr && sg && host_cmd.part == SEHIER_SP_POLL_MASK && host_cmd.wdata[7:0] == 8'h00
      |-> ##3 !poll_flag [*5];
  endproperty
  a_poll_off: assert property (p_poll_off) else $error("poll flag with empty mask");
  property p_poll_on;
    error_queue_nonempty [*8] ##0 (wr && sg && host_cmd.part == SEHIER_SP_POLL_MASK
      && host_cmd.wdata[7:0] == 8'h04) |-> ##3 poll_flag;
  endproperty
  a_poll_on: assert property (p_poll_on) else $error("poll flag missed error queue");
  c_request: cover property (service_request);
  c_poll: cover property (poll_flag);
  c_events: cover property (host_rsp.valid && host_rsp.rdata != 16'h0000);
endmodule
bind sehier_top sehier_checker u_checker (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .host_cmd(host_cmd),
  .host_rsp(host_rsp),
  .oper_src(oper_src),
  .error_queue_nonempty(error_queue_nonempty),
  .service_request(service_request),
  .poll_flag(poll_flag)
);
`default_nettype wire

// file: sehier_host_model.sv
// model: host controller issuing status commands and collecting answers
`timescale 1ns/10ps
`default_nettype none
module sehier_host_model
  import sehier_pkg::*;
(
  input wire logic clk_sys,
  output sehier_pkg::sehier_cmd_s host_cmd,
  input wire sehier_pkg::sehier_rsp_s host_rsp
);
  logic [15:0] rdata;
  logic slow = 1'b0;
  initial host_cmd = '0;
  // ----
  // commands: entered just after an edge, left up so the next one chains on
  // ----
  task automatic op(input logic w, input logic [2:0] r, p, input logic [15:0] d);
    host_cmd = '{1'b1, w, r, p, d};
    @(posedge clk_sys);
    #1;
    // a missing answer shows as unknown so the comparison fails
    rdata = (host_rsp.valid === 1'b1) ? host_rsp.rdata : 16'hxxxx;
    if (slow) begin
      host_cmd = '0;
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic cyc(input int n);
    host_cmd = '0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// testbench: self-checking bench for the status event hierarchy
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sehier_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  sehier_cmd_s host_cmd;
  sehier_rsp_s host_rsp;
  logic [15:0] oper_src, ques_src, dev_src;
  logic [7:0] std_event_pulse;
  logic error_queue_nonempty, message_waiting;
  logic service_request, poll_flag, seen_srq;
  int bad_count = 0, comparisons = 0, cycles = 0;
  logic [31:0] seed = 32'hc;
  always #50 clk_sys = ~clk_sys;
  sehier_top DUT (
    .clk_sys(clk_sys), .resetn(resetn), .host_cmd(host_cmd), .host_rsp(host_rsp),
    .oper_src(oper_src), .ques_src(ques_src), .dev_src(dev_src),
    .std_event_pulse(std_event_pulse), .error_queue_nonempty(error_queue_nonempty),
    .message_waiting(message_waiting), .service_request(service_request),
    .poll_flag(poll_flag)
  );
  sehier_host_model host (.clk_sys(clk_sys), .host_cmd(host_cmd), .host_rsp(host_rsp));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] exp_evt(input logic [15:0] a, b, ri, fa);
    return ((~a & b & ri) | (a & ~b & fa)) & 16'h7fff;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wr(input logic [2:0] r, p, input logic [15:0] d);
    host.op(1'b1, r, p, d);
  endtask
  task automatic rd(input logic [2:0] r, p);
    host.op(1'b0, r, p, 16'h0000);
  endtask
  task automatic watch_srq(input int n);
    seen_srq = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      seen_srq = seen_srq | service_request;
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    logic [15:0] d, a, b, ri, fa, mk, ev;
    int r;
    oper_src = 16'h0000;
    ques_src = 16'h0000;
    dev_src = 16'h0000;
    std_event_pulse = 8'h00;
    error_queue_nonempty = 1'b0;
    message_waiting = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    host.slow = 1'b1;
    for (int g = 0; g < 5; g++) begin
      for (int q = 0; q < 5; q++) begin
        rd(3'(g), 3'(q));
        check("reset value", host.rdata, (g < 3 && q == 1) ? 16'h7fff : 16'h0000);
      end
    end
    host.slow = 1'b0;
    for (int i = 0; i < 9; i++) begin
      r = int'(rnd() % 3);
      d = 16'(rnd());
      wr(3'(r), (i % 3 == 2) ? SEHIER_PART_MASK : 3'(i % 3 + 1), d);
      rd(3'(r), (i % 3 == 2) ? SEHIER_PART_MASK : 3'(i % 3 + 1));
      check("filter or mask", host.rdata, d & 16'h7fff);
      rd(3'(r), (i % 3 == 2) ? SEHIER_PART_MASK : 3'(i % 3 + 1));
      check("reread", host.rdata, d & 16'h7fff);
      wr(3'(r), SEHIER_PART_LIVE, d);
      wr(3'(r), SEHIER_PART_EVT, d);
      rd(3'(r), SEHIER_PART_LIVE);
      check("live after write", host.rdata, 16'h0000);
      rd(3'(r), SEHIER_PART_EVT);
      check("events after write", host.rdata, 16'h0000);
    end
    for (int i = 0; i < 6; i++) begin
      ri = 16'(rnd());
      fa = 16'(rnd());
      mk = 16'(rnd());
      wr(SEHIER_REG_OPER, SEHIER_PART_RISE, ri);
      wr(SEHIER_REG_OPER, SEHIER_PART_FALL, fa);
      wr(SEHIER_REG_OPER, SEHIER_PART_MASK, mk);
      a = oper_src;
      b = 16'(rnd());
      oper_src = b;
      ques_src = 16'(rnd());
      error_queue_nonempty = 1'(rnd());
      message_waiting = 1'(rnd());
      host.cyc(9);
      ev = exp_evt(a, b, ri, fa);
      rd(SEHIER_REG_SUMMARY, SEHIER_SP_BYTE);
      check("summary bits", host.rdata & 16'h0094, {8'h00, |(ev & mk), 2'b00,
        message_waiting, 1'b0, error_queue_nonempty, 2'b00});
      rd(SEHIER_REG_OPER, SEHIER_PART_EVT);
      check("events", host.rdata, ev);
      rd(SEHIER_REG_OPER, SEHIER_PART_EVT);
      check("events cleared", host.rdata, 16'h0000);
      // bit 0 carries the device sum, which stays low here
      rd(SEHIER_REG_QUES, SEHIER_PART_LIVE);
      check("ques live", host.rdata, ques_src & 16'h7ffe);
    end
    // device sum climbs through the questionable register to a request
    // flush events left by the random questionable inputs first
    rd(SEHIER_REG_QUES, SEHIER_PART_EVT);
    wr(SEHIER_REG_SUMMARY, SEHIER_SP_SRQ_MASK, 16'h0008);
    wr(SEHIER_REG_DEV, SEHIER_PART_RISE, 16'h0001);
    wr(SEHIER_REG_DEV, SEHIER_PART_MASK, 16'h0001);
    wr(SEHIER_REG_QUES, SEHIER_PART_RISE, 16'h0001);
    wr(SEHIER_REG_QUES, SEHIER_PART_MASK, 16'h0001);
    host.cyc(1);
    dev_src = 16'h0001;
    watch_srq(30);
    check("service request", 16'(seen_srq), 16'h0001);
    rd(SEHIER_REG_SUMMARY, SEHIER_SP_BYTE);
    check("device and ques summaries", host.rdata & 16'h000a, 16'h000a);
    rd(SEHIER_REG_QUES, SEHIER_PART_EVT);
    check("ques event", host.rdata, 16'h0001);
    wr(SEHIER_REG_SUMMARY, SEHIER_SP_SRQ_MASK, 16'h0040);
    wr(SEHIER_REG_SUMMARY, SEHIER_SP_STD_MASK, 16'h0001);
    rd(SEHIER_REG_SUMMARY, SEHIER_SP_SRQ_MASK);
    check("request mask bit 6", host.rdata, 16'h0000);
    host.cyc(1);
    // pins need two agreeing samples, so a one-cycle pulse would be filtered
    std_event_pulse = 8'h01;
    host.cyc(2);
    std_event_pulse = 8'h00;
    watch_srq(12);
    check("request masked off", 16'(seen_srq), 16'h0000);
    rd(SEHIER_REG_SUMMARY, SEHIER_SP_BYTE);
    check("std event summary", host.rdata & 16'h0020, 16'h0020);
    rd(SEHIER_REG_SUMMARY, SEHIER_SP_STD_FLAGS);
    check("std flags", host.rdata, 16'h0001);
    rd(SEHIER_REG_SUMMARY, SEHIER_SP_STD_FLAGS);
    check("std flags cleared", host.rdata, 16'h0000);
    error_queue_nonempty = 1'b1;
    host.cyc(9);
    wr(SEHIER_REG_SUMMARY, SEHIER_SP_POLL_MASK, 16'h0004);
    host.cyc(4);
    check("poll flag", 16'(poll_flag), 16'h0001);
    wr(SEHIER_REG_SUMMARY, SEHIER_SP_SRQ_MASK, 16'h0004);
    wr(SEHIER_REG_SUMMARY, SEHIER_SP_POLL_MASK, 16'h0040);
    host.cyc(5);
    check("poll via master bit", 16'(poll_flag), 16'h0001);
    wr(SEHIER_REG_SUMMARY, SEHIER_SP_POLL_MASK, 16'h0000);
    host.cyc(8);
    check("poll off", 16'(poll_flag), 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
